// ---- fepa_pkg.sv ----
// Package: flash sequencer constants and carrier types
package fepa_pkg;
  // ==================================================
  // Commands
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
  localparam logic [7:0] CMD_PROG_VERIFY  = 8'hC0;
  localparam logic [7:0] CMD_READ         = 8'h00;
  // ==================================================
  // Data values
  localparam logic [7:0]  DATA_ZERO  = 8'h00;
  localparam logic [7:0]  DATA_ERASED = 8'hFF;
  localparam int          ADDR_W     = 18;
  localparam logic [17:0] ADDR_FIRST = 18'h00000;
  localparam logic [17:0] ADDR_LAST  = 18'h3FFFF;
  localparam logic [4:0]  MAX_PULSES = 5'h19;
  // ==================================================
  // Timing
  localparam int CLK_HZ        = 20000000;
  localparam int PROG_TIME_NS  = 10000;
  localparam int ERASE_TIME_US = 9500;
  localparam int RECOV_TIME_NS = 6000;
  localparam int PROG_CYC  = (PROG_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int ERASE_CYC = ERASE_TIME_US * (CLK_HZ / 1000000);
  localparam int RECOV_CYC = (RECOV_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int BUS_CYC   = 4;
  // ==================================================
  // Bus cycle request and pins
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fepa_req_s;
  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
  } fepa_pins_s;
endpackage

// ---- fepa_bus.sv ----
// Single flash bus cycle engine
`timescale 1ns/1ns
module fepa_bus (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              start,
  input  wire fepa_pkg::fepa_req_s req,
  input  wire logic [7:0]        dq_in,
  output logic                   done,
  output logic [7:0]             rd_data,
  output fepa_pkg::fepa_pins_s   pins,
  output logic [7:0]             dq_out,
  output logic                   dq_oe_n
);
  logic [2:0] cnt, next_cnt;
  logic       busy, next_busy, next_done;
  logic [7:0] next_rd_data, dq_s1, dq_s2;
  fepa_pkg::fepa_pins_s next_pins;
  logic [7:0] next_dq_out;
  logic       next_dq_oe_n;

  // ==================================================
  // Cycle sequencing
  always_comb begin
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    next_rd_data = rd_data;
    next_pins = pins;
    next_dq_out = dq_out;
    next_dq_oe_n = dq_oe_n;
    if (!busy && start) begin
      next_busy = 1'b1;
      next_cnt = 3'h0;
      next_pins.addr = req.addr;
      next_pins.ce_n = 1'b0;
      next_pins.we_n = !req.wr;
      next_pins.oe_n = req.wr;
      next_dq_out = req.data;
      next_dq_oe_n = !req.wr;
    end else if (busy) begin
      next_cnt = cnt + 3'h1;
      if (cnt == 3'(fepa_pkg::BUS_CYC - 1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_pins.ce_n = 1'b1;
        next_pins.we_n = 1'b1;
        next_pins.oe_n = 1'b1;
        next_dq_oe_n = 1'b1;
        if (!pins.oe_n) begin
          next_rd_data = dq_s2;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 3'h0;
      busy <= 1'b0;
      done <= 1'b0;
      rd_data <= 8'h00;
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 18'h00000};
      dq_out <= 8'h00;
      dq_oe_n <= 1'b1;
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
      rd_data <= next_rd_data;
      pins <= next_pins;
      dq_out <= next_dq_out;
      dq_oe_n <= next_dq_oe_n;
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end
endmodule

// ---- fepa_ctrl.sv ----
// Flash erase and program controller top
// Operation
// - Before erasing, every byte is programmed to 00h through the program loop.
// - Writing 20h twice in a row starts chip erase.
// - Writing A0h with an address then reading checks that byte against FFh.
// - Erase verify starts at address 0 and walks upward to the last address or a failure.
// - On a failing byte, its address is kept, erase is repeated, and verify resumes there.
// - Programming repeats 10 us pulses on one byte until verify passes.
// - No byte receives more than 25 program pulses.
// - 40h arms programming and the next write latches address and data and starts the pulse.
// - After a pulse, C0h is written, a read follows, and the byte is compared with its data.
`timescale 1ns/1ns
module fepa_ctrl (
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic                    cmd_erase,
  input  wire logic                    cmd_prog,
  input  wire logic [17:0]             cmd_addr,
  input  wire logic [7:0]              cmd_data,
  input  wire logic [7:0]              dq_in,
  output logic                         busy,
  output logic                         done,
  output logic                         fail,
  output logic [17:0]                  fail_addr,
  output fepa_pkg::fepa_pins_s         pins,
  output logic [7:0]                   dq_out,
  output logic                         dq_oe_n
);
  typedef enum logic [9:0] {
    S_IDLE   = 10'b0000000001,
    S_PSETUP = 10'b0000000010,
    S_PWRITE = 10'b0000000100,
    S_PWAIT  = 10'b0000001000,
    S_PVCMD  = 10'b0000010000,
    S_PVREAD = 10'b0000100000,
    S_ESETUP = 10'b0001000000,
    S_EWAIT  = 10'b0010000000,
    S_EVCMD  = 10'b0100000000,
    S_EVREAD = 10'b1000000000
  } fepa_state_e;

  fepa_state_e         state, next_state;
  logic                erase_job, next_erase_job, pre_prog, next_pre_prog;
  logic                es_second, next_es_second;
  logic [17:0]         addr, next_addr;
  logic [7:0]          data, next_data;
  logic [4:0]          pulses, next_pulses;
  logic [17:0]         wait_cnt, next_wait_cnt;
  logic                bus_start, next_bus_start, bus_pend, next_bus_pend;
  fepa_pkg::fepa_req_s req, next_req;
  logic                bus_done;
  logic [7:0]          rd_data;
  logic                next_busy, next_done, next_fail;
  logic [17:0]         next_fail_addr;

  fepa_bus u_bus (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .start   (bus_start),
    .req     (req),
    .dq_in   (dq_in),
    .done    (bus_done),
    .rd_data (rd_data),
    .pins    (pins),
    .dq_out  (dq_out),
    .dq_oe_n (dq_oe_n)
  );

  function automatic fepa_pkg::fepa_req_s mk_req(input logic wr, input logic [17:0] a, input logic [7:0] d);
    mk_req = '{wr: wr, addr: a, data: d};
  endfunction

  // ==================================================
  // Sequencer
  always_comb begin
    next_state = state;
    next_erase_job = erase_job;
    next_pre_prog = pre_prog;
    next_es_second = es_second;
    next_addr = addr;
    next_data = data;
    next_pulses = pulses;
    next_wait_cnt = wait_cnt;
    next_bus_start = 1'b0;
    next_bus_pend = bus_pend;
    next_req = req;
    next_busy = busy;
    next_done = 1'b0;
    next_fail = fail;
    next_fail_addr = fail_addr;
    if (!bus_pend && !bus_start) begin
      case (state)
        S_IDLE: begin
          if (cmd_erase) begin
            next_busy = 1'b1;
            next_fail = 1'b0;
            next_erase_job = 1'b1;
            next_pre_prog = 1'b1;
            next_addr = fepa_pkg::ADDR_FIRST;
            next_data = fepa_pkg::DATA_ZERO;
            next_pulses = 5'h00;
            next_state = S_PSETUP;
          end else if (cmd_prog) begin
            next_busy = 1'b1;
            next_fail = 1'b0;
            next_erase_job = 1'b0;
            next_pre_prog = 1'b0;
            next_addr = cmd_addr;
            next_data = cmd_data;
            next_pulses = 5'h00;
            next_state = S_PSETUP;
          end
        end
        S_PSETUP: begin
          next_req = mk_req(1'b1, addr, fepa_pkg::CMD_PROG_SETUP);
          next_bus_start = 1'b1;
          next_bus_pend = 1'b1;
          next_state = S_PWRITE;
        end
        S_PWRITE: begin
          next_req = mk_req(1'b1, addr, data);
          next_bus_start = 1'b1;
          next_bus_pend = 1'b1;
          next_pulses = pulses + 5'h01;
          next_wait_cnt = 18'(fepa_pkg::PROG_CYC);
          next_state = S_PWAIT;
        end
        S_PWAIT: begin
          if (wait_cnt == 18'h00000) begin
            next_state = S_PVCMD;
          end else begin
            next_wait_cnt = wait_cnt - 18'h00001;
          end
        end
        S_PVCMD: begin
          next_req = mk_req(1'b1, addr, fepa_pkg::CMD_PROG_VERIFY);
          next_bus_start = 1'b1;
          next_bus_pend = 1'b1;
          next_wait_cnt = 18'(fepa_pkg::RECOV_CYC);
          next_state = S_PVREAD;
        end
        S_PVREAD: begin
          if (wait_cnt != 18'h00000) begin
            next_wait_cnt = wait_cnt - 18'h00001;
          end else begin
            next_req = mk_req(1'b0, addr, data);
            next_bus_start = 1'b1;
            next_bus_pend = 1'b1;
            next_state = S_IDLE;
            next_wait_cnt = 18'h3FFFF;
          end
        end
        S_ESETUP: begin
          next_req = mk_req(1'b1, addr, fepa_pkg::CMD_ERASE_SETUP);
          next_bus_start = 1'b1;
          next_bus_pend = 1'b1;
          next_es_second = !es_second;
          if (es_second) begin
            next_wait_cnt = 18'(fepa_pkg::ERASE_CYC);
            next_state = S_EWAIT;
          end
        end
        S_EWAIT: begin
          if (wait_cnt == 18'h00000) begin
            next_state = S_EVCMD;
          end else begin
            next_wait_cnt = wait_cnt - 18'h00001;
          end
        end
        S_EVCMD: begin
          next_req = mk_req(1'b1, addr, fepa_pkg::CMD_ERASE_VERIFY);
          next_bus_start = 1'b1;
          next_bus_pend = 1'b1;
          next_wait_cnt = 18'(fepa_pkg::RECOV_CYC);
          next_state = S_EVREAD;
        end
        S_EVREAD: begin
          if (wait_cnt != 18'h00000) begin
            next_wait_cnt = wait_cnt - 18'h00001;
          end else begin
            next_req = mk_req(1'b0, addr, data);
            next_bus_start = 1'b1;
            next_bus_pend = 1'b1;
            next_state = S_IDLE;
            next_wait_cnt = 18'h3FFFF;
          end
        end
        default: next_state = S_IDLE;
      endcase
    end else if (bus_done) begin
      next_bus_pend = 1'b0;
      if (state == S_IDLE && wait_cnt == 18'h3FFFF) begin
        next_wait_cnt = 18'h00000;
        if (!erase_job || pre_prog) begin
          if (rd_data == data) begin
            next_pulses = 5'h00;
            if (erase_job && addr != fepa_pkg::ADDR_LAST) begin
              next_addr = addr + 18'h00001;
              next_state = S_PSETUP;
            end else if (erase_job) begin
              next_pre_prog = 1'b0;
              next_addr = fepa_pkg::ADDR_FIRST;
              next_es_second = 1'b0;
              next_state = S_ESETUP;
            end else begin
              next_busy = 1'b0;
              next_done = 1'b1;
            end
          end else if (pulses == fepa_pkg::MAX_PULSES) begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_fail = 1'b1;
            next_fail_addr = addr;
          end else begin
            next_state = S_PSETUP;
          end
        end else if (rd_data == fepa_pkg::DATA_ERASED) begin
          if (addr == fepa_pkg::ADDR_LAST) begin
            next_busy = 1'b0;
            next_done = 1'b1;
          end else begin
            next_addr = addr + 18'h00001;
            next_state = S_EVCMD;
          end
        end else begin
          next_es_second = 1'b0;
          next_state = S_ESETUP;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
      erase_job <= 1'b0;
      pre_prog <= 1'b0;
      es_second <= 1'b0;
      addr <= 18'h00000;
      data <= 8'h00;
      pulses <= 5'h00;
      wait_cnt <= 18'h00000;
      bus_start <= 1'b0;
      bus_pend <= 1'b0;
      req <= '{wr: 1'b0, addr: 18'h00000, data: 8'h00};
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      fail_addr <= 18'h00000;
    end else begin
      state <= next_state;
      erase_job <= next_erase_job;
      pre_prog <= next_pre_prog;
      es_second <= next_es_second;
      addr <= next_addr;
      data <= next_data;
      pulses <= next_pulses;
      wait_cnt <= next_wait_cnt;
      bus_start <= next_bus_start;
      bus_pend <= next_bus_pend;
      req <= next_req;
      busy <= next_busy;
      done <= next_done;
      fail <= next_fail;
      fail_addr <= next_fail_addr;
    end
  end
endmodule

// ---- fepa_ctrl_assertions.sv ----
// Port checks for the flash erase and program controller
`timescale 1ns/1ns
module fepa_chk (
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  input wire logic                 cmd_prog,
  input wire logic                 busy,
  input wire logic                 done,
  input wire logic                 fail,
  input wire logic [17:0]          fail_addr,
  input wire fepa_pkg::fepa_pins_s pins,
  input wire logic [7:0]           dq_out,
  input wire logic                 dq_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Write tracking
  logic        we_d;
  logic        armed;
  logic        after_prog;
  logic [8:0]  gap;
  logic [5:0]  npulse;
  logic [17:0] paddr;
  wire         wr_go = we_d && !pins.we_n;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      we_d <= 1'b1;
      armed <= 1'b0;
      after_prog <= 1'b0;
      gap <= '0;
      npulse <= '0;
      paddr <= '0;
    end else begin
      we_d <= pins.we_n;
      if (gap != 9'h1FF) gap <= gap + 9'h001;
      if (done) npulse <= '0;
      if (wr_go) begin
        armed <= (dq_out == fepa_pkg::CMD_PROG_SETUP) && !armed;
        after_prog <= armed;
        if (armed) begin
          gap <= '0;
          paddr <= pins.addr;
          npulse <= (pins.addr == paddr) ? npulse + 6'h01 : 6'h01;
        end
      end
    end
  end
  // ==========================================
  // Sequences
  sequence access_s;
    (!pins.ce_n && $stable(pins.addr))[*3] ##1 pins.ce_n;
  endsequence
  sequence read_s;
    pins.we_n throughout (##[1:400] !pins.oe_n);
  endsequence
  // ==========================================
  // Assertions
  bus_access_a: assert property ($fell(pins.ce_n) |=> access_s)
    else $error("bus access length wrong");
  bus_gap_a: assert property ($rose(pins.ce_n) |-> pins.ce_n[*2])
    else $error("bus idle gap too short");
  no_contend_a: assert property (!pins.oe_n |-> dq_oe_n && pins.we_n)
    else $error("data driven during read");
  drive_write_a: assert property (!dq_oe_n |-> !pins.we_n && !pins.ce_n)
    else $error("data driven outside write");
  pulse_time_a: assert property (wr_go && after_prog |-> gap >= fepa_pkg::PROG_CYC)
    else $error("program pulse cut short");
  verify_code_a: assert property (wr_go && after_prog |-> dq_out == fepa_pkg::CMD_PROG_VERIFY)
    else $error("no verify after pulse");
  verify_read_a: assert property (wr_go && dq_out == fepa_pkg::CMD_PROG_VERIFY |-> ##4 read_s)
    else $error("no read after verify code");
  pulse_limit_a: assert property (npulse <= {1'b0, fepa_pkg::MAX_PULSES})
    else $error("too many pulses on one byte");
  fail_report_a: assert property ($rose(fail) |-> done && fail_addr == paddr)
    else $error("failure report wrong");
  done_pulse_a: assert property (done |=> !done && !busy)
    else $error("done not a single pulse");
  start_busy_a: assert property (!busy && !done && cmd_prog |=> busy)
    else $error("command not taken");
endmodule

bind fepa_ctrl fepa_chk chk_u (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_prog(cmd_prog), .busy(busy),
  .done(done), .fail(fail), .fail_addr(fail_addr), .pins(pins), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

// ---- fepa_flash_model.sv ----
// Behavioural byte-wide flash device
`timescale 1ns/1ns
module fepa_flash_model (
  input  wire fepa_pkg::fepa_pins_s pins,
  input  wire logic [7:0]           dq_out,
  input  wire logic                 dq_oe_n,
  input  wire logic [5:0]           need,
  output logic [7:0]                dq_in,
  output int                        pulses,
  output logic                      early,
  output logic                      margin
);
  logic [7:0]  mem [logic [17:0]];
  logic [7:0]  mode = 8'h00;
  logic [17:0] paddr = '0;
  logic [17:0] vaddr = '0;
  logic [7:0]  idle_v = 8'h00;
  time         t_prog = 0;
  logic        pend_p = 1'b0;
  function automatic logic [7:0] rd(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  initial begin
    pulses = 0;
    early = 1'b0;
  end
  assign margin = (mode == 8'h40) || (mode == 8'hC0);
  assign dq_in = (!pins.ce_n && !pins.oe_n) ?
    rd(mode == 8'hC0 ? paddr : mode == 8'hA0 ? vaddr : pins.addr) : idle_v;
  always @(negedge pins.oe_n) #1 idle_v = ~dq_in;
  // Program pulse starts as the write strobe rises
  always @(posedge pins.we_n) begin
    if (pend_p) begin
      t_prog = $time;
      pend_p = 1'b0;
    end
  end
  // Settle past the strobe edge before sampling the other pins
  always @(negedge pins.we_n) begin
    #1;
    if (!pins.ce_n && !dq_oe_n) begin
      if (mode == 8'h40) begin
        pulses = (pins.addr == paddr) ? pulses + 1 : 1;
        paddr = pins.addr;
        pend_p = 1'b1;
        if (pulses >= need) mem[paddr] = rd(paddr) & dq_out;
        mode = 8'h00;
      end else if (mode == 8'h20 && dq_out == 8'h20) begin
        mem.delete();
        mode = 8'h00;
      end else begin
        mode = dq_out;
        if (dq_out == 8'hA0) vaddr = pins.addr;
        if (dq_out == 8'hC0 && $time - t_prog < 10001) early = 1'b1;
      end
    end
  end
endmodule

// ---- tb_flash_erase_program_algorithm.sv ----
// Self-checking bench for the flash erase and program controller
`timescale 1ns/1ns
module tb_flash_erase_program_algorithm;
  logic                 sys_clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 cmd_erase = 1'b0;
  logic                 cmd_prog = 1'b0;
  logic [17:0]          cmd_addr = '0;
  logic [7:0]           cmd_data = '0;
  logic [7:0]           dq_in;
  logic                 busy;
  logic                 done;
  logic                 fail;
  logic [17:0]          fail_addr;
  fepa_pkg::fepa_pins_s pins;
  logic [7:0]           dq_out;
  logic                 dq_oe_n;
  logic [5:0]           need = 6'h01;
  int                   fails = 0;
  int                   n_tests = 0;
  always #25 sys_clk = ~sys_clk;
  fepa_ctrl dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_erase(cmd_erase), .cmd_prog(cmd_prog),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .dq_in(dq_in), .busy(busy), .done(done), .fail(fail),
    .fail_addr(fail_addr), .pins(pins), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
  fepa_flash_model flash_u (.pins(pins), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .need(need), .dq_in(dq_in),
    .pulses(), .early(), .margin());
  // ==========================================
  // Shared tasks
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic prog_job(input logic [17:0] a, input logic [7:0] d, input logic [5:0] k, input logic poke);
    int i;
    need <= k;
    @(posedge sys_clk);
    cmd_prog <= 1'b1;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge sys_clk);
    cmd_prog <= 1'b0;
    cmd_erase <= poke;
    @(posedge sys_clk);
    cmd_erase <= 1'b0;
    for (i = 0; i < 20000; i++) begin
      @(negedge sys_clk);
      if (done === 1'b1) return;
    end
    check(1'b0, "done timeout");
    results();
  endtask
  // ==========================================
  // Scenarios
  task automatic t_first();
    check(flash_u.rd(18'h12345) === 8'hFF, "blank byte not erased");
    prog_job(18'h3FFFF, 8'h5A, 6'h01, 1'b1);
    check(fail === 1'b0 && flash_u.pulses == 1, "single pulse job");
    check(flash_u.rd(18'h3FFFF) === 8'h5A, "byte not programmed");
    repeat (4) @(negedge sys_clk);
    check(busy === 1'b0, "command taken while busy");
    $display("test first done");
  endtask
  task automatic t_retry();
    prog_job(18'h00010, 8'hA5, 6'h05, 1'b0);
    check(flash_u.pulses == 5 && fail === 1'b0, "retry count");
    check(flash_u.early === 1'b0, "pulse shorter than 10 us");
    $display("test retry done");
  endtask
  task automatic t_limit();
    prog_job(18'h00020, 8'h00, 6'h1E, 1'b0);
    check(flash_u.pulses == 25, "pulse limit");
    check(fail === 1'b1 && fail_addr === 18'h00020, "failure report");
    prog_job(18'h00021, 8'h3C, 6'h01, 1'b0);
    check(fail === 1'b0 && flash_u.rd(18'h00021) === 8'h3C, "back to back job");
    $display("test limit done");
  endtask
  task automatic t_erase();
    int i;
    need <= 6'h01;
    @(posedge sys_clk);
    cmd_erase <= 1'b1;
    @(posedge sys_clk);
    cmd_erase <= 1'b0;
    for (i = 0; i < 2000 && pins.oe_n !== 1'b0; i++) @(negedge sys_clk);
    if (i == 2000) begin
      check(1'b0, "verify read timeout");
      results();
    end
    check(flash_u.paddr === 18'h0 && flash_u.rd(18'h0) === 8'h00, "pre-program");
    check(flash_u.margin === 1'b1, "margin off in verify");
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(busy === 1'b0 && pins.ce_n === 1'b1 && dq_oe_n === 1'b1, "reset state");
    reset_n <= 1'b1;
    repeat (2) @(negedge sys_clk);
    check(busy === 1'b0 && done === 1'b0 && pins.ce_n === 1'b1, "idle after reset");
    $display("test erase done");
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_first();
    t_retry();
    t_limit();
    t_erase();
    results();
  end
endmodule
